// ===== hdl/chg_command_logic.sv
// smbus slave, set-point registers, status, alert and current mapping of the charger
`timescale 1ns/1ps

// How it works
// - write-word command 0x16 is the warning command and may set the lockout
// - warning bits 15 or 14 set the lockout; bit 12 is not decoded and has no effect
// - lockout holds until pack removal, defaults restore, or a new set point
// - write-word: address, write bit, command, low, high, each byte acknowledged
// - read-word: command write, repeated start, low byte then high, host nacks
// - commands 0x12, 0x14, 0x15 carry mode, current and voltage words
// - read-word of 0x13 returns thermistor and charger state
// - temp-high and lockout clear on pack removal or defaults restore
// - irq_n falls on supply power-up, pack change or power-lost change
// - pack and power-lost interrupts each have a mask in the mode word
// - irq_n stays low until a status read or alert-response read
// - alert-response byte 0x19 is answered with 0x13
// - current bits 11..7 form the fast code; lower bits select trickle only
// - fast code is clamped to the full scale chosen by full_scale_select
// - trickle off when blocked, locked out, or the hot condition holds
// - trickle on needs voltage set, small current, and loop allowing it
// - defaults restore loads voltage ffff and current 0007
// - mode bit 5 masks pack, bit 6 masks power-lost, zero means both edges
// - mode bit 0 blocks charging and sets the blocked flag
module chg_command_logic (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire chg_pkg::chg_pins_s pins,
    output logic irq_n,
    output logic trickle_on,
    output logic [4:0] fast_current_code,
    output logic fast_charge_en
);
    // link domain: bytes are shifted in on the bus clock itself
    logic [7:0] link_shift;
    always_ff @(posedge scl) begin
        link_shift <= {link_shift[6:0], sda_in};
    end

    // synchronisers for bus lines and analog status
    logic scl_meta, scl_s, scl_d, sda_meta, sda_s, sda_d;
    chg_pkg::chg_pins_s pins_meta, pins_s;
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            scl_meta <= 1'b1;
            scl_s <= 1'b1;
            scl_d <= 1'b1;
            sda_meta <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
            pins_meta <= '0;
            pins_s <= '0;
        end else begin
            scl_meta <= scl;
            scl_s <= scl_meta;
            scl_d <= scl_s;
            sda_meta <= sda_in;
            sda_s <= sda_meta;
            sda_d <= sda_s;
            pins_meta <= pins;
            pins_s <= pins_meta;
        end
    end

    logic rise, fall, start, stop;
    assign rise = scl_s & ~scl_d;
    assign fall = ~scl_s & scl_d;
    assign start = scl_s & scl_d & sda_d & ~sda_s;
    assign stop = scl_s & scl_d & ~sda_d & sda_s;
    // open drain: only ever pulls low
    assign sda_out = 1'b0;

    chg_pkg::chg_phase_e phase;
    logic [3:0] bitcnt;
    logic [7:0] cmd, data_lo, data_hi, tx, tx_hi;
    logic ack_pend, have_hi, rd_first, wr_done, rd_done;
    logic wr_commit, rd_commit;
    logic [15:0] word;
    chg_pkg::chg_status_s status;
    logic lockout, temp_high, inhibit, pack_mask, pwr_mask, heat_shutdown_enable;
    logic [15:0] volt_set, cur_set;

    assign word = {data_hi, data_lo};
    // a transfer only takes effect once the stop ends it
    assign wr_commit = stop & wr_done;
    assign rd_commit = stop & rd_done;

    assign status.power_lost = pins_s.power_lost;
    assign status.pack_inserted = pins_s.pack_inserted;
    assign status.spare = '0;
    assign status.alarm_lockout = lockout;
    assign status.temp_high = temp_high;
    assign status.temp_under_range = pins_s.therm_under;
    assign status.volt_not_reg = pins_s.volt_not_reg;
    assign status.volt_loop_low = pins_s.volt_loop_low;
    assign status.heat_shutdown = heat_shutdown_enable;
    assign status.charging_blocked = inhibit;

    // byte-level protocol engine
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            phase <= chg_pkg::PH_IDLE;
            bitcnt <= 4'h0;
            cmd <= 8'h00;
            data_lo <= 8'h00;
            data_hi <= 8'h00;
            tx <= 8'h00;
            tx_hi <= 8'h00;
            ack_pend <= 1'b0;
            have_hi <= 1'b0;
            rd_first <= 1'b0;
            wr_done <= 1'b0;
            rd_done <= 1'b0;
            sda_oe <= 1'b0;
        end else if (start) begin
            phase <= chg_pkg::PH_ADDR;
            bitcnt <= 4'h0;
            sda_oe <= 1'b0;
            wr_done <= 1'b0;
            rd_done <= 1'b0;
        end else if (stop) begin
            phase <= chg_pkg::PH_IDLE;
            bitcnt <= 4'h0;
            sda_oe <= 1'b0;
            wr_done <= 1'b0;
            rd_done <= 1'b0;
        end else if (rise && phase != chg_pkg::PH_IDLE) begin
            bitcnt <= bitcnt + 4'h1;
            if (bitcnt == chg_pkg::BYTE_BITS - 4'h1) begin
                ack_pend <= 1'b0;
                unique case (phase)
                    chg_pkg::PH_ADDR: begin
                        if (link_shift[7:1] == chg_pkg::DEV_ADDR && !link_shift[0]) begin
                            phase <= chg_pkg::PH_CMD;
                            ack_pend <= 1'b1;
                        end else if (link_shift[7:1] == chg_pkg::DEV_ADDR
                                     && cmd == chg_pkg::CMD_STATUS) begin
                            phase <= chg_pkg::PH_READ;
                            tx <= status[7:0];
                            tx_hi <= status[15:8];
                            have_hi <= 1'b1;
                            rd_first <= 1'b1;
                            ack_pend <= 1'b1;
                        end else if (link_shift == chg_pkg::ALERT_BYTE && !irq_n) begin
                            phase <= chg_pkg::PH_READ;
                            tx <= chg_pkg::ALERT_REPLY;
                            have_hi <= 1'b0;
                            rd_first <= 1'b1;
                            ack_pend <= 1'b1;
                        end else begin
                            phase <= chg_pkg::PH_IGNORE;
                        end
                    end
                    chg_pkg::PH_CMD: begin
                        cmd <= link_shift;
                        if (link_shift >= chg_pkg::CMD_MODE
                            && link_shift <= chg_pkg::CMD_WARNING) begin
                            phase <= chg_pkg::PH_LOW;
                            ack_pend <= 1'b1;
                        end else begin
                            phase <= chg_pkg::PH_IGNORE;
                        end
                    end
                    chg_pkg::PH_LOW: begin
                        data_lo <= link_shift;
                        phase <= chg_pkg::PH_HIGH;
                        ack_pend <= 1'b1;
                    end
                    chg_pkg::PH_HIGH: begin
                        data_hi <= link_shift;
                        wr_done <= cmd != chg_pkg::CMD_STATUS;
                        phase <= chg_pkg::PH_IGNORE;
                        ack_pend <= 1'b1;
                    end
                    chg_pkg::PH_IDLE, chg_pkg::PH_READ, chg_pkg::PH_IGNORE: begin
                    end
                endcase
            end
            if (bitcnt == chg_pkg::BYTE_BITS && phase == chg_pkg::PH_READ && !rd_first) begin
                // host nack on the last byte completes the read
                rd_done <= sda_s & ~have_hi;
            end
        end else if (fall && phase != chg_pkg::PH_IDLE) begin
            if (bitcnt == chg_pkg::BYTE_BITS) begin
                sda_oe <= ack_pend;
            end else if (bitcnt == chg_pkg::ACK_SLOT) begin
                bitcnt <= 4'h0;
                sda_oe <= 1'b0;
                if (phase == chg_pkg::PH_READ) begin
                    if (rd_first) begin
                        rd_first <= 1'b0;
                        sda_oe <= ~tx[7];
                    end else if (have_hi && !rd_done) begin
                        tx <= tx_hi;
                        have_hi <= 1'b0;
                        sda_oe <= ~tx_hi[7];
                    end
                end
            end else if (phase == chg_pkg::PH_READ && bitcnt != 4'h0) begin
                sda_oe <= ~tx[3'(4'h7 - bitcnt)];
            end else begin
                sda_oe <= 1'b0;
            end
        end
    end

    // set points; removal of the pack returns them to power-up values
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            volt_set <= chg_pkg::VOLT_POR;
            cur_set <= chg_pkg::CUR_POR;
        end else if (!pins_s.pack_inserted) begin
            volt_set <= chg_pkg::VOLT_POR;
            cur_set <= chg_pkg::CUR_POR;
        end else if (wr_commit) begin
            if (cmd == chg_pkg::CMD_MODE && word[chg_pkg::MODE_DEFAULTS]) begin
                volt_set <= chg_pkg::VOLT_DEFAULT;
                cur_set <= chg_pkg::CUR_POR;
            end else if (cmd == chg_pkg::CMD_VOLTAGE) begin
                volt_set <= word;
            end else if (cmd == chg_pkg::CMD_CURRENT) begin
                cur_set <= word;
            end
        end
    end

    // mode word fields
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            inhibit <= chg_pkg::INHIBIT_POR;
            pack_mask <= chg_pkg::PACK_MASK_POR;
            pwr_mask <= chg_pkg::PWR_MASK_POR;
            heat_shutdown_enable <= chg_pkg::HEAT_SHUTDOWN_ENABLE_POR;
        end else begin
            if (wr_commit && cmd == chg_pkg::CMD_MODE) begin
                inhibit <= word[chg_pkg::MODE_INHIBIT];
                pack_mask <= word[chg_pkg::MODE_PACK_MASK];
                pwr_mask <= word[chg_pkg::MODE_PWR_MASK];
                heat_shutdown_enable <= word[chg_pkg::MODE_HEAT_SHUTDOWN_ENABLE];
            end
            if (!pins_s.pack_inserted) begin
                heat_shutdown_enable <= chg_pkg::HEAT_SHUTDOWN_ENABLE_POR;
            end
        end
    end

    // latched status bits; a setting event wins over a clear in the same cycle
    logic warn_set, latch_clr;
    assign warn_set = wr_commit && cmd == chg_pkg::CMD_WARNING
                      && (word[chg_pkg::WARN_OVERCHARGE] | word[chg_pkg::WARN_END_CHARGE]);
    assign latch_clr = !pins_s.pack_inserted
                       || (wr_commit && cmd == chg_pkg::CMD_MODE && word[chg_pkg::MODE_DEFAULTS]);
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            lockout <= 1'b0;
        end else if (warn_set) begin
            lockout <= 1'b1;
        end else if (latch_clr || (wr_commit && (cmd == chg_pkg::CMD_VOLTAGE
                                                 || cmd == chg_pkg::CMD_CURRENT))) begin
            lockout <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            temp_high <= 1'b0;
        end else if (pins_s.therm_hot) begin
            temp_high <= 1'b1;
        end else if (latch_clr) begin
            temp_high <= 1'b0;
        end
    end

    // interrupt request
    logic supply_d, pack_d, pwr_d, irq_event;
    assign irq_event = (pins_s.supply_on & ~supply_d)
                       | ((pins_s.pack_inserted ^ pack_d) & ~pack_mask)
                       | ((pins_s.power_lost ^ pwr_d) & ~pwr_mask);
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            supply_d <= 1'b0;
            pack_d <= 1'b0;
            pwr_d <= 1'b0;
            irq_n <= 1'b1;
        end else begin
            supply_d <= pins_s.supply_on;
            pack_d <= pins_s.pack_inserted;
            pwr_d <= pins_s.power_lost;
            if (irq_event) begin
                irq_n <= 1'b0;
            end else if (rd_commit) begin
                irq_n <= 1'b1;
            end
        end
    end

    // current source control
    logic hot, blocked, volt_ok;
    logic [15:0] fs_limit;
    logic [4:0] next_code;
    assign hot = temp_high & heat_shutdown_enable & ~pins_s.therm_under;
    assign blocked = inhibit | lockout | hot;
    assign volt_ok = volt_set >= chg_pkg::VOLT_MIN;
    always_comb begin
        unique case (pins_s.fs_sel)
            chg_pkg::FS_SEL_VL: fs_limit = chg_pkg::FS_LIMIT_VL;
            chg_pkg::FS_SEL_OPEN: fs_limit = chg_pkg::FS_LIMIT_OPEN;
            default: fs_limit = chg_pkg::FS_LIMIT_GND;
        endcase
        if (cur_set > fs_limit) begin
            next_code = fs_limit[chg_pkg::CODE_MSB:chg_pkg::CODE_LSB];
        end else begin
            next_code = cur_set[chg_pkg::CODE_MSB:chg_pkg::CODE_LSB];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            trickle_on <= 1'b0;
            fast_current_code <= 5'h00;
            fast_charge_en <= 1'b0;
        end else begin
            fast_current_code <= next_code;
            fast_charge_en <= !blocked && volt_ok && next_code != 5'h00;
            trickle_on <= !blocked && volt_ok
                          && cur_set != chg_pkg::CUR_ZERO && cur_set <= chg_pkg::TRICKLE_MAX
                          && (!pins_s.volt_loop_low || pins_s.volt_not_reg);
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);

    warn_lockout_a: assert property (warn_set |=> lockout)
        else $error("warning write did not set lockout");
    lockout_hold_a: assert property (lockout && !wr_commit
        && pins_s.pack_inserted |=> lockout) else $error("lockout dropped without cause");
    defaults_a: assert property (wr_commit && cmd == chg_pkg::CMD_MODE
        && word[chg_pkg::MODE_DEFAULTS] && pins_s.pack_inserted |=> !lockout
        && volt_set == chg_pkg::VOLT_DEFAULT && cur_set == chg_pkg::CUR_POR)
        else $error("defaults restore mismatch");
    pack_clear_a: assert property (!pins_s.pack_inserted && !pins_s.therm_hot
        && !warn_set |=> !temp_high && !lockout)
        else $error("latched bits survived pack removal");
    irq_pack_a: assert property ((pins_s.pack_inserted != pack_d) && !pack_mask
        |=> !irq_n ##1 !irq_n)
        else $error("pack change did not raise irq");
    irq_hold_a: assert property (!irq_n && !rd_commit |=> !irq_n)
        else $error("irq released without completed read");
    trickle_off_a: assert property (inhibit || lockout |=> !trickle_on)
        else $error("trickle on while blocked");
    clamp_vl_a: assert property (pins_s.fs_sel == chg_pkg::FS_SEL_VL
        && cur_set > chg_pkg::FS_LIMIT_VL |=> fast_current_code == 5'h1f)
        else $error("full scale clamp wrong");
    ack_drive_a: assert property (fall && !start && !stop
        && phase != chg_pkg::PH_IDLE && bitcnt == chg_pkg::BYTE_BITS && ack_pend |=> sda_oe)
        else $error("ack not driven");
    alert_reply_a: assert property (rise && phase == chg_pkg::PH_ADDR
        && !start && !stop && bitcnt == 4'h7 && link_shift == chg_pkg::ALERT_BYTE && !irq_n
        |=> tx == chg_pkg::ALERT_REPLY && phase == chg_pkg::PH_READ)
        else $error("alert reply not loaded");
    inhibit_set_a: assert property (wr_commit && cmd == chg_pkg::CMD_MODE
        && word[chg_pkg::MODE_INHIBIT] |=> inhibit ##1 !trickle_on && !fast_charge_en)
        else $error("inhibit did not block charging");
endmodule : chg_command_logic

// ===== hdl/chg_pkg.sv
// constants, field layouts and carrier types of the charger command logic
package chg_pkg;
    // bus addressing
    localparam logic [6:0] DEV_ADDR = 7'h09;
    localparam logic [7:0] ALERT_BYTE = 8'h19;
    localparam logic [7:0] ALERT_REPLY = 8'h13;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] ACK_SLOT = 4'h9;

    // command codes
    localparam logic [7:0] CMD_MODE = 8'h12;
    localparam logic [7:0] CMD_STATUS = 8'h13;
    localparam logic [7:0] CMD_CURRENT = 8'h14;
    localparam logic [7:0] CMD_VOLTAGE = 8'h15;
    localparam logic [7:0] CMD_WARNING = 8'h16;

    // mode word fields
    localparam int MODE_INHIBIT = 0;
    localparam int MODE_DEFAULTS = 2;
    localparam int MODE_PACK_MASK = 5;
    localparam int MODE_PWR_MASK = 6;
    localparam int MODE_HEAT_SHUTDOWN_ENABLE = 10;
    localparam logic PACK_MASK_POR = 1'b0;
    localparam logic PWR_MASK_POR = 1'b1;
    localparam logic HEAT_SHUTDOWN_ENABLE_POR = 1'b1;
    localparam logic INHIBIT_POR = 1'b0;

    // warning word fields
    localparam int WARN_OVERCHARGE = 15;
    localparam int WARN_END_CHARGE = 14;
    localparam int WARN_OVERHEAT = 12;

    // set-point values
    localparam logic [15:0] VOLT_POR = 16'h47f0;
    localparam logic [15:0] VOLT_DEFAULT = 16'hffff;
    localparam logic [15:0] CUR_POR = 16'h0007;
    localparam logic [15:0] VOLT_MIN = 16'h0010;
    localparam logic [15:0] TRICKLE_MAX = 16'h007f;
    localparam logic [15:0] CUR_ZERO = 16'h0000;
    localparam logic [15:0] FS_LIMIT_GND = 16'h0380;
    localparam logic [15:0] FS_LIMIT_OPEN = 16'h0b80;
    localparam logic [15:0] FS_LIMIT_VL = 16'h0f80;
    localparam int CODE_MSB = 11;
    localparam int CODE_LSB = 7;

    // full_scale_select pin encoding
    localparam logic [1:0] FS_SEL_GND = 2'h0;
    localparam logic [1:0] FS_SEL_OPEN = 2'h1;
    localparam logic [1:0] FS_SEL_VL = 2'h2;

    typedef enum logic [2:0] {
        PH_IDLE, PH_ADDR, PH_CMD, PH_LOW, PH_HIGH, PH_READ, PH_IGNORE
    } chg_phase_e;

    // analog and strap inputs, all asynchronous to mclk
    typedef struct packed {
        logic pack_inserted;
        logic supply_on;
        logic power_lost;
        logic therm_hot;
        logic therm_under;
        logic volt_loop_low;
        logic volt_not_reg;
        logic [1:0] fs_sel;
    } chg_pins_s;

    // word returned by status_command, msb first
    typedef struct packed {
        logic power_lost;
        logic pack_inserted;
        logic [6:0] spare;
        logic alarm_lockout;
        logic temp_high;
        logic temp_under_range;
        logic volt_not_reg;
        logic volt_loop_low;
        logic heat_shutdown;
        logic charging_blocked;
    } chg_status_s;
endpackage : chg_pkg

// ===== tb/chg_host_model.sv
// host smbus master model: scl from its own 15 ns base clock, open-drain pull on sda
`timescale 1ns/1ps
module chg_host_model (
    output logic scl,
    output logic sda_pull,
    input wire logic sda
);
    logic lclk;
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
        lclk = 1'b0;
        #3.3;
        forever #7.5 lclk = ~lclk;
    end
    // scl halves last four base periods so the mclk synchroniser sees every edge
    task automatic quarter();
        repeat (2) @(posedge lclk);
    endtask : quarter
    task automatic start();
        sda_pull <= 1'b0;
        quarter();
        scl <= 1'b1;
        quarter();
        sda_pull <= 1'b1;
        quarter();
        scl <= 1'b0;
        quarter();
    endtask : start
    // scl is left high afterwards: the clock stands still between frames
    task automatic stop();
        sda_pull <= 1'b1;
        quarter();
        scl <= 1'b1;
        quarter();
        sda_pull <= 1'b0;
        quarter();
    endtask : stop
    task automatic xbit(input logic b, output logic r);
        sda_pull <= ~b;
        quarter();
        scl <= 1'b1;
        quarter();
        r = sda;
        quarter();
        scl <= 1'b0;
        quarter();
    endtask : xbit
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xbit(d[i], r);
        end
        xbit(1'b1, r);
        ack = ~r;
    endtask : wbyte
    task automatic rbyte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xbit(1'b1, d[i]);
        end
        xbit(nack, r);
    endtask : rbyte
endmodule : chg_host_model

// ===== tb/charger_smbus_command_logic_tb_top.sv
// self-checking bench for the charger smbus command logic
`timescale 1ns/1ps
module charger_smbus_command_logic_tb_top;
    logic mclk;
    logic rstn;
    logic scl;
    logic host_pull;
    logic sda_oe;
    logic irq_n;
    logic trickle_on;
    logic [4:0] fast_current_code;
    logic fast_charge_en;
    chg_pkg::chg_pins_s pins;
    int error_cnt = 0;
    int total_checks = 0;
    int cycles = 0;
    logic ok;
    logic [15:0] w;
    logic [7:0] b;
    logic sda_lvl;
    wire sda = ((sda_oe && !sda_lvl) || host_pull) ? 1'b0 : 1'b1;
    chg_command_logic dut (.mclk(mclk), .rstn(rstn), .scl(scl), .sda_in(sda), .sda_out(sda_lvl),
        .sda_oe(sda_oe), .pins(pins), .irq_n(irq_n), .trickle_on(trickle_on),
        .fast_current_code(fast_current_code), .fast_charge_en(fast_charge_en));
    chg_host_model host (.scl(scl), .sda_pull(host_pull), .sda(sda));
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            error_cnt = error_cnt + 1;
            summarize();
        end
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic settle();
        repeat (12) @(posedge mclk);
    endtask : settle
    task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
        logic [3:0] a;
        host.start();
        host.wbyte({chg_pkg::DEV_ADDR, 1'b0}, a[0]);
        host.wbyte(cmd, a[1]);
        host.wbyte(d[7:0], a[2]);
        host.wbyte(d[15:8], a[3]);
        host.stop();
        ok = &a;
        settle();
    endtask : wr
    // full low stops right after the command byte, an aborted status read
    task automatic rd(input logic full, output logic [15:0] d);
        logic a;
        d = 16'h0000;
        host.start();
        host.wbyte({chg_pkg::DEV_ADDR, 1'b0}, a);
        host.wbyte(chg_pkg::CMD_STATUS, a);
        if (full) begin
            host.start();
            host.wbyte({chg_pkg::DEV_ADDR, 1'b1}, a);
            host.rbyte(1'b0, d[7:0]);
            host.rbyte(1'b1, d[15:8]);
        end
        host.stop();
        settle();
    endtask : rd
    task automatic t_power_up();
        check("irq_n", irq_n, 1'b0);
        rd(1'b1, w);
        check("status", w, 16'h4002);
        check("irq_n", irq_n, 1'b1);
        check("trickle", trickle_on, 1'b1);
        pins.volt_loop_low <= 1'b1;
        settle();
        check("trickle", trickle_on, 1'b0);
        pins.volt_not_reg <= 1'b1;
        settle();
        check("trickle", trickle_on, 1'b1);
        $display("power-up test done");
    endtask : t_power_up
    task automatic t_clamp();
        logic [1:0] fs [4] = '{chg_pkg::FS_SEL_GND, chg_pkg::FS_SEL_OPEN,
            chg_pkg::FS_SEL_VL, chg_pkg::FS_SEL_VL};
        logic [15:0] cur [4] = '{16'h0400, 16'h0c00, 16'h1000, 16'h0080};
        logic [4:0] code [4] = '{5'h07, 5'h17, 5'h1f, 5'h01};
        for (int i = 0; i < 4; i++) begin
            pins.fs_sel <= fs[i];
            wr(chg_pkg::CMD_CURRENT, cur[i]);
            check("fast code", fast_current_code, code[i]);
            check("fast enable", fast_charge_en, 1'b1);
        end
        check("trickle", trickle_on, 1'b0);
        $display("clamp test done");
    endtask : t_clamp
    task automatic t_lockout();
        wr(chg_pkg::CMD_WARNING, 16'h1000);
        rd(1'b1, w);
        check("lockout", w[6], 1'b0);
        wr(chg_pkg::CMD_WARNING, 16'h8000);
        check("warning ack", ok, 1'b1);
        rd(1'b1, w);
        check("lockout", w[6], 1'b1);
        check("fast enable", fast_charge_en, 1'b0);
        wr(chg_pkg::CMD_VOLTAGE, 16'h47f0);
        rd(1'b1, w);
        check("lockout", w[6], 1'b0);
        wr(chg_pkg::CMD_WARNING, 16'h4000);
        wr(chg_pkg::CMD_MODE, 16'hffd4);
        rd(1'b1, w);
        check("lockout", w[6], 1'b0);
        check("trickle", trickle_on, 1'b1);
        check("fast code", fast_current_code, 5'h00);
        wr(chg_pkg::CMD_MODE, 16'hffd1);
        rd(1'b1, w);
        // loop-low and not-regulating pins are still high from the power-up test
        check("status low", w[6:0], 7'h0f);
        check("trickle", trickle_on, 1'b0);
        wr(8'h20, 16'h0000);
        check("unmapped ack", ok, 1'b0);
        $display("lockout test done");
    endtask : t_lockout
    task automatic t_irq();
        pins.power_lost <= 1'b1;
        settle();
        check("irq_n", irq_n, 1'b1);
        wr(chg_pkg::CMD_MODE, 16'hff90);
        pins.power_lost <= 1'b0;
        settle();
        check("irq_n", irq_n, 1'b0);
        rd(1'b0, w);
        check("irq_n", irq_n, 1'b0);
        host.start();
        host.wbyte(chg_pkg::ALERT_BYTE, ok);
        check("alert ack", ok, 1'b1);
        host.rbyte(1'b1, b);
        host.stop();
        settle();
        check("alert reply", b, 8'h13);
        check("irq_n", irq_n, 1'b1);
        pins.pack_inserted <= 1'b0;
        settle();
        check("irq_n", irq_n, 1'b0);
        rd(1'b1, w);
        check("status", w, 16'h000e);
        wr(chg_pkg::CMD_MODE, 16'hffb0);
        pins.pack_inserted <= 1'b1;
        settle();
        check("irq_n", irq_n, 1'b1);
        $display("interrupt test done");
    endtask : t_irq
    // hot latch blocks charging while therm_under is low, until heat shutdown is disabled or defaults restore
    task automatic t_hot();
        pins.therm_hot <= 1'b1;
        settle();
        check("trickle", trickle_on, 1'b0);
        pins.therm_under <= 1'b1;
        settle();
        check("trickle", trickle_on, 1'b1);
        pins.therm_under <= 1'b0;
        pins.therm_hot <= 1'b0;
        wr(chg_pkg::CMD_MODE, 16'hfbb0);
        rd(1'b1, w);
        check("status", w, 16'h402c);
        check("trickle", trickle_on, 1'b1);
        wr(chg_pkg::CMD_MODE, 16'hffb4);
        rd(1'b1, w);
        check("status", w, 16'h400e);
        $display("thermal test done");
    endtask : t_hot
    initial begin
        rstn = 1'b0;
        pins = '0;
        pins.pack_inserted = 1'b1;
        pins.supply_on = 1'b1;
        pins.fs_sel = chg_pkg::FS_SEL_VL;
        repeat (20) @(posedge mclk);
        rstn <= 1'b1;
        repeat (8) @(posedge mclk);
        t_power_up();
        t_clamp();
        t_lockout();
        t_irq();
        t_hot();
        summarize();
    end
endmodule : charger_smbus_command_logic_tb_top
